// ==== ccd_pkg.sv ====
// Constants for the cascaded channel clock divider.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one register a word.
package ccd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] CCD_IDX_S1_COUNTS   = 10'h19e;
  localparam logic [9:0] CCD_IDX_PHASES      = 10'h19f;
  localparam logic [9:0] CCD_IDX_S2_COUNTS   = 10'h1a0;
  localparam logic [9:0] CCD_IDX_CONTROL     = 10'h1a1;
  localparam logic [9:0] CCD_IDX_DUTY        = 10'h1a2;
  localparam logic [9:0] CCD_IDX_STATUS      = 10'h1a3;

  localparam int unsigned CCD_ADDR_W         = 12;
  localparam int unsigned CCD_DATA_W         = 32;
  localparam int unsigned CCD_CNT_W          = 4;

  // Nibble positions in count and phase registers
  localparam int unsigned CCD_HI_NIB_LSB     = 4;
  localparam int unsigned CCD_LO_NIB_LSB     = 0;

  // Control register bit positions
  localparam int unsigned CCD_BIT_BYP2       = 5;
  localparam int unsigned CCD_BIT_BYP1       = 4;
  localparam int unsigned CCD_BIT_NOSYNC     = 3;
  localparam int unsigned CCD_BIT_FORCE      = 2;
  localparam int unsigned CCD_BIT_START2     = 1;
  localparam int unsigned CCD_BIT_START1     = 0;

  // Duty register bit position
  localparam int unsigned CCD_BIT_DCC_OFF    = 0;

  // Status register bit positions
  localparam int unsigned CCD_BIT_ST_S1      = 0;
  localparam int unsigned CCD_BIT_ST_S2      = 1;
  localparam int unsigned CCD_BIT_ST_OUT     = 2;
  localparam int unsigned CCD_BIT_ST_SYNC    = 3;
  localparam int unsigned CCD_BIT_ST_HOLD    = 4;

  // Values after reset
  localparam logic [7:0] CCD_RST_REG8        = 8'h00;
  localparam logic [3:0] CCD_RST_NIB         = 4'h0;
  localparam logic [4:0] CCD_RST_CNT         = 5'h00;

endpackage : ccd_pkg

// ==== ccd_divider.sv ====
// How it works
// - Second stage stays low for its low count plus one input cycles.
// - Second stage stays high for its high count plus one input cycles.
// - First stage uses own low and high counts, each count plus one.
// - Second stage bypass freezes its counter and passes its input through.
// - First stage bypass freezes its counter and passes its input through.
// - Ignore-sync clear: both stages obey sync; set: stages ignore sync, which then applies the force level.
// - Force bit sets static pair output level; needs ignore-sync set and sync asserted.
// - Second stage start-level bit picks its initial output level.
// - First stage start-level bit picks its initial output level.
// - Duty correction on while disable bit is zero, off when one.
// - Phase offsets: second stage upper nibble, first stage lower nibble.
//
// Holds one divider stage and the channel pair top with its register file.
// Assumes the distribution clock is CLK_SYS and sync arrives on a pin.
`timescale 1ns/10ps

module ccd_stage
  import ccd_pkg::*;
#(
  parameter int unsigned CNT_W = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_tick,
  input  wire logic             in_lvl,
  input  wire logic             bypass,
  input  wire logic             start_high,
  input  wire logic             hold,
  input  wire logic [CNT_W-1:0] low_cnt,
  input  wire logic [CNT_W-1:0] high_cnt,
  input  wire logic [CNT_W-1:0] phase,
  output logic                  lvl,
  output logic                  tick
);

  // One extra bit so phase plus level count never wraps
  logic [CNT_W:0] cnt;
  logic [CNT_W:0] next_cnt;
  logic           next_lvl;
  logic [CNT_W:0] start_len;

  assign start_len = start_high ? {1'b0, high_cnt} : {1'b0, low_cnt};

  always_comb begin
    next_cnt = cnt;
    next_lvl = lvl;
    if (hold) begin
      next_lvl = start_high;
      next_cnt = {1'b0, phase} + start_len;
    end else if (bypass) begin
      // Counter frozen as if powered down
      next_lvl = in_lvl;
    end else if (in_tick) begin
      if (cnt == '0) begin
        next_lvl = ~lvl;
        next_cnt = lvl ? {1'b0, low_cnt}
                       : {1'b0, high_cnt};
      end else begin
        next_cnt = cnt - (CNT_W+1)'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= CCD_RST_CNT[CNT_W:0];
      lvl <= 1'b0;
    end else begin
      cnt <= next_cnt;
      lvl <= next_lvl;
    end
  end

  // A bypassed stage passes the input tick, a held stage gives none; otherwise one tick per rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else if (hold) begin
      tick <= 1'b0;
    end else if (bypass) begin
      tick <= in_tick;
    end else begin
      tick <= in_tick && !lvl && (cnt == '0);
    end
  end

  a_low_reload: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!hold && !bypass && in_tick && lvl && cnt == '0)
    |=> (!lvl && cnt == {1'b0, $past(low_cnt)}))
    else $error("low phase not reloaded with low count");

  a_high_reload: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!hold && !bypass && in_tick && !lvl && cnt == '0)
    |=> (lvl && cnt == {1'b0, $past(high_cnt)}))
    else $error("high phase not reloaded with high count");

  // Mid-phase ticks only count down; the level must not move early
  a_count_down: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!hold && !bypass && in_tick && cnt != '0)
    |=> (cnt == $past(cnt) - (CNT_W+1)'(1) && $stable(lvl)))
    else $error("stage counter did not step down by one");

  a_bypass_pass: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!hold && bypass) |=> (lvl == $past(in_lvl) && $stable(cnt)))
    else $error("bypassed stage did not pass input or kept counting");

  a_bypass_tick: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!hold && bypass) |=> tick == $past(in_tick))
    else $error("bypassed stage did not pass its input tick");

  a_sync_start: assert property (
    @(posedge clk) disable iff (!rst_n)
    hold |=> (lvl == $past(start_high) && !tick))
    else $error("held stage not at its start level");

  a_phase_delay: assert property (
    @(posedge clk) disable iff (!rst_n)
    hold |=> cnt == $past({1'b0, phase}) + $past(start_len))
    else $error("phase offset not loaded on sync");

endmodule : ccd_stage

module ccd_divider
  import ccd_pkg::*;
#(
  parameter int unsigned CNT_W = CCD_CNT_W
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RSTN,
  input  wire logic [CCD_ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [CCD_DATA_W-1:0] AVS_WRITEDATA,
  input  wire logic [3:0]            AVS_BYTEENABLE,
  output logic      [CCD_DATA_W-1:0] AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  input  wire logic                  CHIP_SYNC_N,
  output logic                       STAGE1_CLK,
  output logic                       PAIR_CLK,
  output logic                       DUTY_CORR_EN
);

  logic [7:0]      s1_counts;
  logic [7:0]      phases;
  logic [7:0]      s2_counts;
  logic [7:0]      control;
  logic            duty_correction_disable;
  logic            sync_meta;
  logic            sync_act;
  logic            hold;
  logic            in_lvl;
  logic            s1_lvl;
  logic            s1_tick;
  logic            s2_lvl;
  logic            force_on;
  logic            wr_en;
  logic [9:0]      idx;
  logic [7:0]      status;
  logic [CCD_DATA_W-1:0] next_rdata;

  assign idx   = AVS_ADDRESS[CCD_ADDR_W-1:2];
  // A write lands only on the edge that ends its wait
  assign wr_en = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];

  // Avalon slave: one wait cycle for every access
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b0;
    end else begin
      AVS_WAITREQUEST <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s1_counts <= CCD_RST_REG8;
      phases    <= CCD_RST_REG8;
      s2_counts <= CCD_RST_REG8;
      control   <= CCD_RST_REG8;
    end else if (wr_en) begin
      case (idx)
        CCD_IDX_S1_COUNTS: s1_counts <= AVS_WRITEDATA[7:0];
        CCD_IDX_PHASES:    phases    <= AVS_WRITEDATA[7:0];
        CCD_IDX_S2_COUNTS: s2_counts <= AVS_WRITEDATA[7:0];
        CCD_IDX_CONTROL:   control   <= {2'h0, AVS_WRITEDATA[5:0]};
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      duty_correction_disable <= 1'b0;
    end else if (wr_en && idx == CCD_IDX_DUTY) begin
      duty_correction_disable <= AVS_WRITEDATA[CCD_BIT_DCC_OFF];
    end
  end

  assign status = {3'h0, hold, sync_act, PAIR_CLK, s2_lvl, s1_lvl};

  always_comb begin
    next_rdata = '0;
    case (idx)
      CCD_IDX_S1_COUNTS: next_rdata[7:0] = s1_counts;
      CCD_IDX_PHASES:    next_rdata[7:0] = phases;
      CCD_IDX_S2_COUNTS: next_rdata[7:0] = s2_counts;
      CCD_IDX_CONTROL:   next_rdata[7:0] = control;
      CCD_IDX_DUTY:
        next_rdata[CCD_BIT_DCC_OFF] = duty_correction_disable;
      CCD_IDX_STATUS:    next_rdata[7:0] = status;
      default:           next_rdata = '0;
    endcase
  end

  // Captured while waiting, so data stand on the releasing edge
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      AVS_READDATA <= '0;
    end else if (AVS_READ && AVS_WAITREQUEST) begin
      AVS_READDATA <= next_rdata;
    end
  end

  // Sync pin is asynchronous; first flop feeds only the second
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sync_meta <= 1'b0;
      sync_act  <= 1'b0;
    end else begin
      sync_meta <= !CHIP_SYNC_N;
      sync_act  <= sync_meta;
    end
  end

  assign hold     = sync_act && !control[CCD_BIT_NOSYNC];
  // Forced level only reaches the pin while sync is being ignored
  assign force_on = sync_act && control[CCD_BIT_NOSYNC];

  // Stands in for the distribution clock as a level when stage one passes it
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      in_lvl <= 1'b0;
    end else begin
      in_lvl <= ~in_lvl;
    end
  end

  ccd_stage #(
    .CNT_W (CNT_W)
  ) u_stage1 (
    .clk        (CLK_SYS),
    .rst_n      (RSTN),
    .in_tick    (1'b1),
    .in_lvl     (in_lvl),
    .bypass     (control[CCD_BIT_BYP1]),
    .start_high (control[CCD_BIT_START1]),
    .hold       (hold),
    .low_cnt    (s1_counts[CCD_HI_NIB_LSB +: CNT_W]),
    .high_cnt   (s1_counts[CCD_LO_NIB_LSB +: CNT_W]),
    .phase      (phases[CCD_LO_NIB_LSB +: CNT_W]),
    .lvl        (s1_lvl),
    .tick       (s1_tick)
  );

  ccd_stage #(
    .CNT_W (CNT_W)
  ) u_stage2 (
    .clk        (CLK_SYS),
    .rst_n      (RSTN),
    .in_tick    (s1_tick),
    .in_lvl     (s1_lvl),
    .bypass     (control[CCD_BIT_BYP2]),
    .start_high (control[CCD_BIT_START2]),
    .hold       (hold),
    .low_cnt    (s2_counts[CCD_HI_NIB_LSB +: CNT_W]),
    .high_cnt   (s2_counts[CCD_LO_NIB_LSB +: CNT_W]),
    .phase      (phases[CCD_HI_NIB_LSB +: CNT_W]),
    .lvl        (s2_lvl),
    .tick       ()
  );

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      STAGE1_CLK <= 1'b0;
      PAIR_CLK   <= 1'b0;
    end else begin
      STAGE1_CLK <= s1_lvl;
      PAIR_CLK   <= force_on ? control[CCD_BIT_FORCE] : s2_lvl;
    end
  end

  // Correction itself is analog; the block only drives its enable
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      DUTY_CORR_EN <= 1'b1;
    end else begin
      DUTY_CORR_EN <= !duty_correction_disable;
    end
  end

  a_nosync_ignore: assert property (
    @(posedge CLK_SYS) disable iff (!RSTN)
    control[CCD_BIT_NOSYNC] |-> !hold)
    else $error("sync obeyed while ignore-sync is set");

  a_sync_obey: assert property (
    @(posedge CLK_SYS) disable iff (!RSTN)
    (sync_act && !control[CCD_BIT_NOSYNC]) |-> hold)
    else $error("sync not obeyed while ignore-sync is clear");

  a_force_level: assert property (
    @(posedge CLK_SYS) disable iff (!RSTN)
    (force_on && $stable(control)) |=>
      PAIR_CLK == $past(control[CCD_BIT_FORCE]))
    else $error("pair output not at forced level");

  a_pair_follow: assert property (
    @(posedge CLK_SYS) disable iff (!RSTN)
    !force_on |=> PAIR_CLK == $past(s2_lvl))
    else $error("pair output not following second stage");

  a_duty_enable: assert property (
    @(posedge CLK_SYS) disable iff (!RSTN)
    ##1 DUTY_CORR_EN == !$past(duty_correction_disable))
    else $error("duty correction enable wrong");

  // The tick is consumed one edge later, so look after it
  a_cascade_tick: assert property (
    @(posedge CLK_SYS) disable iff (!RSTN)
    (s1_tick && !hold && !control[CCD_BIT_BYP2]) |=>
      (!$stable(u_stage2.cnt) || !$stable(u_stage2.lvl)))
    else $error("second stage ignored first stage tick");

  a_bus_answer: assert property (
    @(posedge CLK_SYS) disable iff (!RSTN)
    ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
    else $error("bus access not answered in one cycle");

  a_phase_write: assert property (
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_en && idx == CCD_IDX_PHASES) |=>
      phases == $past(AVS_WRITEDATA[7:0]))
    else $error("phase register write lost");

endmodule : ccd_divider

// ==== ccd_clk_rx.sv ====
// Output clock driver model: measures high and low run lengths.
// Assumes its input is a level that changes on the system clock.
`timescale 1ns/10ps
module ccd_clk_rx (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_in,
  output logic      [7:0] hi_len,
  output logic      [7:0] lo_len
);
  logic       prev;
  logic [7:0] run;

  // Lengths only; a real driver has no view of phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev   <= 1'b0;
      run    <= 8'h00;
      hi_len <= 8'h00;
      lo_len <= 8'h00;
    end else if (clk_in != prev) begin
      prev <= clk_in;
      run  <= 8'h01;
      if (prev) begin
        hi_len <= run;
      end else begin
        lo_len <= run;
      end
    end else begin
      run <= run + 8'h01;
    end
  end
endmodule : ccd_clk_rx

// ==== test_cascaded_channel_clock_divider.sv ====
// Testbench for the cascaded channel clock divider.
// Assumes one 200 MHz clock and byte registers at word addresses.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_cascaded_channel_clock_divider
  import ccd_pkg::*;
;
  logic                  clk_sys        = 1'b0;
  logic                  rstn           = 1'b0;
  logic [CCD_ADDR_W-1:0] avs_address    = '0;
  logic                  avs_read       = 1'b0;
  logic                  avs_write      = 1'b0;
  logic [CCD_DATA_W-1:0] avs_writedata  = '0;
  logic [3:0]            avs_byteenable = 4'h0;
  logic [CCD_DATA_W-1:0] avs_readdata;
  logic                  avs_waitrequest;
  logic                  chip_sync_n    = 1'b1;
  logic                  stage1_clk, pair_clk, duty_corr_en;
  logic [7:0]            s1_hi, s1_lo, p_hi, p_lo, q;
  int                    num_errors = 0;
  int                    num_checks = 0;
  int                    a1, ap, b1, bp;

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  ccd_divider dut_u (.CLK_SYS(clk_sys), .RSTN(rstn),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .CHIP_SYNC_N(chip_sync_n), .STAGE1_CLK(stage1_clk),
    .PAIR_CLK(pair_clk), .DUTY_CORR_EN(duty_corr_en));
  ccd_clk_rx rx1_u (.clk(clk_sys), .rst_n(rstn), .clk_in(stage1_clk),
    .hi_len(s1_hi), .lo_len(s1_lo));
  ccd_clk_rx rx2_u (.clk(clk_sys), .rst_n(rstn), .clk_in(pair_clk),
    .hi_len(p_hi), .lo_len(p_lo));

  task stop_test;
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // Request held until waitrequest is sampled low
  task acc(input logic w, input logic [9:0] i, input logic [7:0] d,
           input logic [3:0] be);
    int n;
    @(posedge clk_sys);
    avs_address    <= {i, 2'b00};
    avs_read       <= ~w;
    avs_write      <= w;
    avs_writedata  <= {24'h000000, d};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      stop_test();
    end
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  task wr(input logic [9:0] i, input logic [7:0] d);
    acc(1'b1, i, d, 4'h1);
  endtask : wr

  task rchk(input logic [9:0] i, input logic [7:0] e);
    acc(1'b0, i, 8'h00, 4'hf);
    `CHK("register", e, q)
  endtask : rchk

  // Holds sync, checks held levels, times first change after release
  task sync_run(input logic e1, input logic e2, output int t1,
                output int tp);
    @(posedge clk_sys);
    chip_sync_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    `CHK("stage1 held", e1, stage1_clk)
    `CHK("pair held", e2, pair_clk)
    rchk(CCD_IDX_STATUS, {3'h0, 2'b11, e2, e2, e1});
    chip_sync_n <= 1'b1;
    t1 = 0;
    tp = 0;
    for (int n = 1; n < 200 && tp == 0; n++) begin
      @(posedge clk_sys);
      if (t1 == 0 && stage1_clk !== e1) t1 = n;
      if (pair_clk !== e2) tp = n;
    end
    if (tp == 0) begin
      num_errors++;
      stop_test();
    end
  endtask : sync_run

  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    `CHK("dcc enable", 1'b1, duty_corr_en)
    // Status moves with the free-running stages, so it is read under sync
    for (int i = 'h19e; i <= 'h1a2; i++) rchk(10'(i), 8'h00);
    wr(CCD_IDX_PHASES, 8'ha5);
    rchk(CCD_IDX_PHASES, 8'ha5);
    acc(1'b1, CCD_IDX_PHASES, 8'h3c, 4'h0);
    rchk(CCD_IDX_PHASES, 8'ha5);
    wr(10'h1a4, 8'h77);
    rchk(10'h1a4, 8'h00);
    wr(CCD_IDX_DUTY, 8'h01);
    repeat (2) @(posedge clk_sys);
    `CHK("dcc off", 1'b0, duty_corr_en)
    wr(CCD_IDX_DUTY, 8'h00);
    repeat (2) @(posedge clk_sys);
    `CHK("dcc on", 1'b1, duty_corr_en)
    wr(CCD_IDX_PHASES, 8'h00);
    wr(CCD_IDX_S1_COUNTS, 8'h12);
    wr(CCD_IDX_S2_COUNTS, 8'h10);
    rchk(CCD_IDX_S2_COUNTS, 8'h10);
    repeat (80) @(posedge clk_sys);
    `CHK("s1 low", 8'h02, s1_lo)
    `CHK("s1 high", 8'h03, s1_hi)
    `CHK("pair low", 8'h0a, p_lo)
    `CHK("pair high", 8'h05, p_hi)
    wr(CCD_IDX_CONTROL, 8'h20);
    repeat (80) @(posedge clk_sys);
    `CHK("byp2 low", 8'h02, p_lo)
    `CHK("byp2 high", 8'h03, p_hi)
    wr(CCD_IDX_CONTROL, 8'h10);
    repeat (80) @(posedge clk_sys);
    `CHK("byp1 low", 8'h01, s1_lo)
    `CHK("byp1 high", 8'h01, s1_hi)
    // Bypassed first stage divides by one: second stage sees every edge
    `CHK("ratio low", 8'h02, p_lo)
    `CHK("ratio high", 8'h01, p_hi)
    wr(CCD_IDX_CONTROL, 8'h00);
    wr(CCD_IDX_S1_COUNTS, 8'h00);
    wr(CCD_IDX_S2_COUNTS, 8'h00);
    sync_run(1'b0, 1'b0, a1, ap);
    wr(CCD_IDX_PHASES, 8'h23);
    sync_run(1'b0, 1'b0, b1, bp);
    `CHK("s1 phase", 3, b1 - a1)
    `CHK("s2 phase", 7, bp - ap)
    wr(CCD_IDX_CONTROL, 8'h03);
    sync_run(1'b1, 1'b1, a1, ap);
    wr(CCD_IDX_CONTROL, 8'h0c);
    @(posedge clk_sys);
    chip_sync_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    `CHK("forced high", 1'b1, pair_clk)
    q[0] = stage1_clk;
    @(posedge clk_sys);
    `CHK("s1 free", ~q[0], stage1_clk)
    wr(CCD_IDX_CONTROL, 8'h08);
    repeat (3) @(posedge clk_sys);
    `CHK("forced low", 1'b0, pair_clk)
    chip_sync_n <= 1'b1;
    stop_test();
  end
endmodule : test_cascaded_channel_clock_divider
